//--- radio_digital_baseband.sv
// What this block does
// RULE_01: take receive converter samples at twelve million per second
// RULE_02: demodulate chips coherently, sync on the standard preamble
// RULE_03: before preamble, update receive gain every half symbol
// RULE_04: after preamble, freeze gain until the packet ends
// RULE_05: despread chips into 4-bit symbols, buffer, hand to the mac
// RULE_06: signal strength every eight symbols and at packet end
// RULE_07: channel busy when strength exceeds threshold, clear otherwise
// RULE_08: spread each 4-bit symbol into its 32-chip sequence
// RULE_09: transmit indicator high in transmit mode
// RULE_10: transmit indicator low in receive mode
// RULE_11: inverted indicator always the complement of the indicator
// RULE_12: indicator on port c line 5, inverse on line 6
// RULE_13: control and calibration words for lna, filter, modulator
// RULE_14: despread each block to the best correlating symbol
`timescale 1ns/1ps
`default_nettype none

module radio_digital_baseband #(
  parameter int RSSI_WIN_CYC = baseband_pkg::RSSI_WIN_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // receive converter and gain
  input wire baseband_pkg::iq_sample_t adc_sample,
  output logic [3:0] rx_gain,
  // mac receive side
  input wire logic rx_packet_end,
  output logic rx_locked,
  output logic [3:0] rx_symbol,
  output logic rx_symbol_valid,
  output logic [7:0] rssi,
  output logic rssi_valid,
  input wire logic [7:0] cca_threshold,
  output logic cca_busy,
  // mac transmit side
  input wire logic tx_mode,
  input wire logic [3:0] tx_symbol,
  input wire logic tx_symbol_valid,
  output logic tx_symbol_ready,
  output logic tx_chip,
  output logic tx_chip_valid,
  // amplifier control and pins
  output logic tx_indicator,
  output logic transmit_indicator_inverted,
  input wire logic port_c5_alt_en,
  input wire logic port_c5_gpio,
  input wire logic port_c6_alt_en,
  input wire logic port_c6_gpio,
  output logic port_c_line_5,
  output logic port_c_line_6,
  // analog calibration
  input wire logic cal_write,
  input wire baseband_pkg::cal_word_t cal_in,
  output baseband_pkg::cal_word_t cal_out
);

  localparam int WIN_W = $clog2(RSSI_WIN_CYC + 1);

  baseband_pkg::iq_sample_t adc_s1_reg, adc_s2_reg;
  baseband_pkg::rx_state_t state_reg;
  logic [7:0] frac_reg;
  logic [8:0] frac_sum;
  logic sample_en_reg;
  logic [2:0] samp_cnt_reg;
  logic chip_par_reg, chip_step_reg;
  logic [31:0] chip_sr_reg;
  logic [4:0] chip_cnt_reg;
  logic [3:0] best_sym;
  logic [5:0] best_score;
  logic [7:0] mag;
  logic [10:0] half_cnt_reg;
  logic agc_tick;
  logic [15:0] agc_acc_reg;
  logic [WIN_W-1:0] win_cnt_reg;
  logic win_end;
  logic [23:0] rssi_acc_reg;
  logic [6:0] tx_cnt_reg;
  logic [31:0] tx_sr_reg;
  logic [4:0] tx_left_reg;
  logic tx_busy_reg;

  // ==========================================================
  // converter input sync and sample rate enable
  always_ff @(posedge clk) begin
    adc_s1_reg <= adc_sample;
    adc_s2_reg <= adc_s1_reg;
  end

  assign frac_sum = {1'b0, frac_reg} + {1'b0, baseband_pkg::SAMPLE_RATE_MSPS};

  always_ff @(posedge clk) begin
    if (rst) begin
      frac_reg <= 8'h00;
      sample_en_reg <= 1'b0;
    end else if (frac_sum >= {1'b0, baseband_pkg::CLK_RATE_MHZ}) begin // RULE_01
      frac_reg <= 8'(frac_sum - {1'b0, baseband_pkg::CLK_RATE_MHZ});
      sample_en_reg <= 1'b1;
    end else begin
      frac_reg <= frac_sum[7:0];
      sample_en_reg <= 1'b0;
    end
  end

  assign mag = adc_s2_reg.i[7] ? 8'(-adc_s2_reg.i) : 8'(adc_s2_reg.i);

  // ==========================================================
  // chip decisions, offset i and q
  always_ff @(posedge clk) begin
    if (rst) begin
      samp_cnt_reg <= 3'h0;
      chip_par_reg <= 1'b0;
      chip_step_reg <= 1'b0;
      chip_sr_reg <= 32'h00000000;
    end else begin
      chip_step_reg <= 1'b0;
      if (sample_en_reg) begin
        if (samp_cnt_reg == baseband_pkg::SAMPLES_PER_CHIP - 3'h1) begin
          samp_cnt_reg <= 3'h0;
        end else begin
          samp_cnt_reg <= samp_cnt_reg + 3'h1;
        end
        if (samp_cnt_reg == 3'h0) begin // RULE_02
          chip_par_reg <= ~chip_par_reg;
          chip_step_reg <= 1'b1;
          chip_sr_reg <= {chip_sr_reg[30:0],
                          chip_par_reg ? ~adc_s2_reg.q[7] : ~adc_s2_reg.i[7]};
        end
      end
    end
  end

  chip_correlator u_corr (
    .chips(chip_sr_reg),
    .best_sym(best_sym),
    .best_score(best_score)
  );

  // ==========================================================
  // preamble search, lock and symbol hand-off
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= baseband_pkg::ST_SEARCH;
      chip_cnt_reg <= 5'h00;
      rx_symbol <= 4'h0;
      rx_symbol_valid <= 1'b0;
    end else begin
      rx_symbol_valid <= 1'b0;
      unique case (state_reg)
        baseband_pkg::ST_SEARCH: begin
          if (chip_step_reg && best_sym == baseband_pkg::PREAMBLE_SYM &&
              best_score >= baseband_pkg::SYNC_SCORE) begin // RULE_02
            state_reg <= baseband_pkg::ST_LOCKED;
            chip_cnt_reg <= 5'h00;
          end
        end
        baseband_pkg::ST_LOCKED: begin
          if (rx_packet_end) begin
            state_reg <= baseband_pkg::ST_SEARCH;
          end else if (chip_step_reg) begin
            chip_cnt_reg <= chip_cnt_reg + 5'h01;
            if (chip_cnt_reg == baseband_pkg::LAST_CHIP) begin // RULE_05
              rx_symbol <= best_sym; // RULE_14
              rx_symbol_valid <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  assign rx_locked = (state_reg == baseband_pkg::ST_LOCKED);

  // ==========================================================
  // gain control
  assign agc_tick = (half_cnt_reg == 11'(baseband_pkg::HALF_SYM_CYC - 1));

  always_ff @(posedge clk) begin
    if (rst) begin
      half_cnt_reg <= 11'h000;
      agc_acc_reg <= 16'h0000;
      rx_gain <= baseband_pkg::GAIN_RESET;
    end else begin
      half_cnt_reg <= agc_tick ? 11'h000 : half_cnt_reg + 11'h001;
      if (agc_tick) begin
        agc_acc_reg <= 16'h0000;
        if (!rx_locked) begin // RULE_03 RULE_04
          if (agc_acc_reg > baseband_pkg::AGC_HIGH_SUM && rx_gain != baseband_pkg::GAIN_MIN) begin
            rx_gain <= rx_gain - 4'h1;
          end else if (agc_acc_reg < baseband_pkg::AGC_LOW_SUM &&
                       rx_gain != baseband_pkg::GAIN_MAX) begin
            rx_gain <= rx_gain + 4'h1;
          end
        end
      end else if (sample_en_reg) begin
        agc_acc_reg <= agc_acc_reg + 16'(mag);
      end
    end
  end

  // ==========================================================
  // signal strength and channel assessment
  assign win_end = (win_cnt_reg == WIN_W'(RSSI_WIN_CYC - 1));

  always_ff @(posedge clk) begin
    if (rst) begin
      win_cnt_reg <= '0;
      rssi_acc_reg <= 24'h000000;
      rssi <= 8'h00;
      rssi_valid <= 1'b0;
      cca_busy <= 1'b0;
    end else begin
      rssi_valid <= 1'b0;
      win_cnt_reg <= (win_end || rx_packet_end) ? '0 : win_cnt_reg + WIN_W'(1);
      if (win_end || (rx_packet_end && rx_locked)) begin // RULE_06
        rssi <= rssi_acc_reg[baseband_pkg::RSSI_LSB +: 8];
        rssi_valid <= 1'b1;
        rssi_acc_reg <= 24'h000000;
      end else if (sample_en_reg) begin
        rssi_acc_reg <= rssi_acc_reg + 24'(mag);
      end
      cca_busy <= (rssi > cca_threshold); // RULE_07
    end
  end

  // ==========================================================
  // transmit spreading
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_cnt_reg <= 7'h00;
      tx_sr_reg <= 32'h00000000;
      tx_left_reg <= 5'h00;
      tx_busy_reg <= 1'b0;
      tx_chip <= 1'b0;
      tx_chip_valid <= 1'b0;
      tx_symbol_ready <= 1'b0;
    end else begin
      tx_chip_valid <= 1'b0;
      tx_symbol_ready <= tx_mode && !tx_busy_reg && !tx_symbol_ready;
      if (tx_symbol_ready && tx_symbol_valid && tx_mode) begin
        tx_sr_reg <= baseband_pkg::spread_seq(tx_symbol); // RULE_08
        tx_left_reg <= baseband_pkg::LAST_CHIP;
        tx_busy_reg <= 1'b1;
        tx_cnt_reg <= 7'h00;
        tx_symbol_ready <= 1'b0;
      end else if (tx_busy_reg) begin
        if (tx_cnt_reg == 7'(baseband_pkg::CHIP_CYC - 1)) begin
          tx_cnt_reg <= 7'h00;
          tx_chip <= tx_sr_reg[31];
          tx_chip_valid <= 1'b1;
          tx_sr_reg <= {tx_sr_reg[30:0], 1'b0};
          tx_left_reg <= tx_left_reg - 5'h01;
          if (tx_left_reg == 5'h00) begin
            tx_busy_reg <= 1'b0;
          end
        end else begin
          tx_cnt_reg <= tx_cnt_reg + 7'h01;
        end
      end
    end
  end

  // ==========================================================
  // amplifier indicator and port c alternate functions
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_indicator <= 1'b0;
      transmit_indicator_inverted <= 1'b1;
      port_c_line_5 <= 1'b0;
      port_c_line_6 <= 1'b0;
    end else begin
      tx_indicator <= tx_mode; // RULE_09 RULE_10
      transmit_indicator_inverted <= ~tx_mode; // RULE_11
      port_c_line_5 <= port_c5_alt_en ? tx_mode : port_c5_gpio; // RULE_12
      port_c_line_6 <= port_c6_alt_en ? ~tx_mode : port_c6_gpio; // RULE_12
    end
  end

  // ==========================================================
  // calibration words to the analog receive and modulator
  always_ff @(posedge clk) begin
    if (rst) begin
      cal_out <= '0;
    end else if (cal_write) begin
      cal_out <= cal_in; // RULE_13
    end
  end

  // ==========================================================
  // checks
  property p_sample_spacing;
    @(posedge clk) disable iff (rst) sample_en_reg |=> !sample_en_reg [*8];
  endproperty
  a_sample_spacing: assert property (p_sample_spacing) // RULE_01
    else $error("sample enable too frequent");

  property p_gain_only_on_tick;
    @(posedge clk) disable iff (rst) $changed(rx_gain) |-> $past(agc_tick) && !$past(rx_locked);
  endproperty
  a_gain_only_on_tick: assert property (p_gain_only_on_tick) // RULE_03
    else $error("gain moved off the half symbol tick");

  property p_gain_frozen;
    @(posedge clk) disable iff (rst) rx_locked && !rx_packet_end |=> $stable(rx_gain);
  endproperty
  a_gain_frozen: assert property (p_gain_frozen) // RULE_04
    else $error("gain moved while locked");

  property p_symbol_when_locked;
    @(posedge clk) disable iff (rst) rx_symbol_valid |-> $past(rx_locked) && $past(chip_step_reg);
  endproperty
  a_symbol_when_locked: assert property (p_symbol_when_locked) // RULE_05
    else $error("symbol delivered without lock");

  property p_rssi_cause;
    @(posedge clk) disable iff (rst) rssi_valid |-> $past(win_end) || $past(rx_packet_end);
  endproperty
  a_rssi_cause: assert property (p_rssi_cause) // RULE_06
    else $error("rssi report without window or packet end");

  property p_cca;
    @(posedge clk) disable iff (rst) ##1 cca_busy == ($past(rssi) > $past(cca_threshold));
  endproperty
  a_cca: assert property (p_cca) // RULE_07
    else $error("cca disagrees with rssi");

  property p_chip_period;
    @(posedge clk) disable iff (rst) tx_chip_valid |=> !tx_chip_valid [*8];
  endproperty
  a_chip_period: assert property (p_chip_period) // RULE_08
    else $error("chips too close together");

  property p_indicator;
    @(posedge clk) disable iff (rst) ##1 tx_indicator == $past(tx_mode);
  endproperty
  a_indicator: assert property (p_indicator) // RULE_09
    else $error("indicator does not follow transmit mode");

  property p_inverse;
    @(posedge clk) disable iff (rst) transmit_indicator_inverted == !tx_indicator;
  endproperty
  a_inverse: assert property (p_inverse) // RULE_11
    else $error("inverted indicator not complement");

  property p_port_c5;
    @(posedge clk) disable iff (rst) port_c5_alt_en ##1 1'b1 |-> port_c_line_5 == tx_indicator;
  endproperty
  a_port_c5: assert property (p_port_c5) // RULE_12
    else $error("port c line 5 not carrying indicator");

endmodule // radio_digital_baseband

`default_nettype wire

//--- baseband_pkg.sv
package baseband_pkg;

  // ==========================================================
  // timing
  localparam int CLK_NS = 4;
  localparam logic [7:0] CLK_RATE_MHZ = 8'hFA;
  localparam logic [7:0] SAMPLE_RATE_MSPS = 8'h0C;
  localparam int CHIP_NS = 500;
  localparam int HALF_SYM_NS = 8000;
  localparam int RSSI_WIN_NS = 128000;
  localparam int CHIP_CYC = CHIP_NS / CLK_NS;
  localparam int HALF_SYM_CYC = HALF_SYM_NS / CLK_NS;
  localparam int RSSI_WIN_CYC = RSSI_WIN_NS / CLK_NS;

  // ==========================================================
  // chip and symbol framing
  localparam logic [2:0] SAMPLES_PER_CHIP = 3'h6;
  localparam logic [4:0] LAST_CHIP = 5'h1F;
  localparam logic [5:0] SYNC_SCORE = 6'h1E;
  localparam logic [3:0] PREAMBLE_SYM = 4'h0;
  localparam logic [31:0] SEQ_BASE = 32'hD9C3522E;
  localparam logic [31:0] ODD_CHIP_MASK = 32'h55555555;

  // ==========================================================
  // gain control and signal strength
  localparam logic [3:0] GAIN_RESET = 4'h8;
  localparam logic [3:0] GAIN_MAX = 4'hF;
  localparam logic [3:0] GAIN_MIN = 4'h0;
  localparam logic [15:0] AGC_HIGH_SUM = 16'h1800;
  localparam logic [15:0] AGC_LOW_SUM = 16'h0600;
  localparam int RSSI_LSB = 11;

  // ==========================================================
  // carriers and states
  typedef struct packed {
    logic signed [7:0] i;
    logic signed [7:0] q;
  } iq_sample_t;

  typedef struct packed {
    logic [5:0] lna;
    logic [5:0] filter;
    logic [5:0] modulation;
  } cal_word_t;

  typedef enum logic {
    ST_SEARCH = 1'b0,
    ST_LOCKED = 1'b1
  } rx_state_t;

  // reference chip sequence, first chip in the msb
  function automatic logic [31:0] spread_seq(input logic [3:0] sym);
    logic [63:0] dbl;
    logic [31:0] seq;
    dbl = {SEQ_BASE, SEQ_BASE} >> {sym[2:0], 2'b00};
    seq = dbl[31:0];
    if (sym[3]) begin
      seq = seq ^ ODD_CHIP_MASK;
    end
    return seq;
  endfunction

endpackage

//--- chip_correlator.sv
`timescale 1ns/1ps
`default_nettype none

module chip_correlator (
  // chips, first in the msb
  input wire logic [31:0] chips,
  // best match
  output logic [3:0] best_sym,
  output logic [5:0] best_score
);

  logic [5:0] score [16];

  // ==========================================================
  // per symbol agreement count
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_ref
      logic [31:0] agree;
      assign agree = ~(chips ^ baseband_pkg::spread_seq(4'(g)));
      assign score[g] = 6'($countones(agree));
    end
  endgenerate

  // ==========================================================
  // pick the strongest match
  always_comb begin
    best_sym = 4'h0;
    best_score = score[0];
    for (int k = 1; k < 16; k++) begin
      if (score[k] > best_score) begin // RULE_14
        best_sym = 4'(k);
        best_score = score[k];
      end
    end
  end

endmodule // chip_correlator

`default_nettype wire

//--- rf_front_end_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// front end: each chip as the sign of both rails
module rf_front_end_model (
  // clock
  input wire logic clk,
  // amplitude
  input wire logic [7:0] amp,
  // converter samples
  output var baseband_pkg::iq_sample_t sample
);
  logic chip_reg = 1'b1;
  assign sample = chip_reg ? {amp, amp} : {8'h00 - amp, 8'h00 - amp};
  // one chip per 125 clocks, msb first
  task automatic send_seq(input logic [31:0] seq);
    for (int k = 31; k >= 0; k--) begin
      @(posedge clk);
      #1;
      chip_reg = seq[k];
      repeat (124) @(posedge clk);
    end
  endtask
endmodule // rf_front_end_model
`default_nettype wire

//--- radio_digital_baseband_test.sv
`timescale 1ns/1ps
`default_nettype none
module radio_digital_baseband_test;
  localparam int WIN = 2048;
  localparam int CHIP = 125;
  localparam logic [3:0] RX_SYMS [4] = '{4'h0, 4'h0, 4'h7, 4'hA};
  localparam logic [3:0] TX_SYMS [6] = '{4'h0, 4'h5, 4'h7, 4'h8, 4'hB, 4'hF};
  logic clk, rst, rx_packet_end, rx_locked, rx_symbol_valid, rssi_valid, cca_busy;
  logic [3:0] rx_gain, rx_symbol, tx_symbol;
  logic [7:0] rssi, cca_threshold, amp;
  logic tx_mode, tx_symbol_valid, tx_symbol_ready, tx_chip, tx_chip_valid;
  logic tx_indicator, transmit_indicator_inverted, port_c_line_5, port_c_line_6;
  logic port_c5_alt_en, port_c5_gpio, port_c6_alt_en, port_c6_gpio, cal_write;
  logic mon_on, exp_busy, exp_ind, exp5, exp6;
  baseband_pkg::iq_sample_t adc_sample;
  baseband_pkg::cal_word_t cal_in, cal_out, exp_cal;
  int n_fail, check_count, cycles;

  // ==========
  // design and front end
  radio_digital_baseband #(.RSSI_WIN_CYC(WIN)) radio_digital_baseband_inst (
    .clk, .rst, .adc_sample, .rx_gain, .rx_packet_end, .rx_locked, .rx_symbol,
    .rx_symbol_valid, .rssi, .rssi_valid, .cca_threshold, .cca_busy, .tx_mode,
    .tx_symbol, .tx_symbol_valid, .tx_symbol_ready, .tx_chip, .tx_chip_valid,
    .tx_indicator, .transmit_indicator_inverted, .port_c5_alt_en, .port_c5_gpio,
    .port_c6_alt_en, .port_c6_gpio, .port_c_line_5, .port_c_line_6, .cal_write,
    .cal_in, .cal_out
  );
  rf_front_end_model rf_front_end_model_inst (.clk(clk), .amp(amp), .sample(adc_sample));

  // ==========
  // helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test;
    if (n_fail == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_high(ref logic s, input int lim, output int t);
    t = 0;
    do begin
      tick(1);
      t++;
    end while (s !== 1'b1 && t < lim);
  endtask

  function automatic logic [31:0] ref_seq(input logic [3:0] s);
    logic [63:0] d;
    d = {32'hD9C3522E, 32'hD9C3522E} >> (4 * s[2:0]);
    return s[3] ? d[31:0] ^ 32'h55555555 : d[31:0];
  endfunction

  // ==========
  // monitor of level outputs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      n_fail++;
      end_of_test();
    end
    if (mon_on) begin
      check("cca busy", cca_busy, exp_busy);
      check("indicator", tx_indicator, exp_ind);
      check("inverted", transmit_indicator_inverted ^ tx_indicator, 1'b1);
      check("line 5", port_c_line_5, exp5);
      check("line 6", port_c_line_6, exp6);
      check("cal", cal_out, exp_cal);
    end
    exp_busy <= rssi > cca_threshold;
    exp_ind <= tx_mode;
    exp5 <= port_c5_alt_en ? tx_mode : port_c5_gpio;
    exp6 <= port_c6_alt_en ? ~tx_mode : port_c6_gpio;
    exp_cal <= rst ? '0 : (cal_write ? cal_in : exp_cal);
  end

  // ==========
  // scenarios
  task automatic test_gain;
    logic [3:0] g;
    for (int p = 0; p < 2; p++) begin
      amp = p ? 8'h64 : 8'h05;
      tick(2000);
      g = p ? rx_gain - 4'h2 : rx_gain + 4'h2;
      tick(4000);
      check("gain step", rx_gain, g);
    end
  endtask

  task automatic test_rssi;
    int t;
    wait_high(rssi_valid, 5000, t);
    wait_high(rssi_valid, 5000, t);
    check("rssi period", t, WIN);
    check("rssi value", rssi, 8'h04);
    cca_threshold = rssi;
    tick(2);
    check("cca clear", cca_busy, 1'b0);
    wait_high(rssi_valid, 5000, t);
    cca_threshold = rssi - 8'h01;
    tick(2);
    check("cca busy set", cca_busy, 1'b1);
    wait_high(rssi_valid, 5000, t);
    wait_high(rssi_valid, 5000, t);
  endtask

  task automatic test_rx;
    logic [3:0] g;
    int t;
    amp = 8'h05;
    check("idle unlocked", rx_locked, 1'b0);
    fork
      for (int k = 0; k < 4; k++) begin
        rf_front_end_model_inst.send_seq(ref_seq(RX_SYMS[k]));
      end
    join_none
    wait_high(rx_locked, 9000, t);
    check("lock", rx_locked, 1'b1);
    g = rx_gain;
    for (int k = 1; k < 4; k++) begin
      wait_high(rx_symbol_valid, 4300, t);
      check("rx symbol", rx_symbol, RX_SYMS[k]);
      check("still locked", rx_locked, 1'b1);
    end
    check("gain frozen", rx_gain, g);
    rx_packet_end = 1'b1;
    tick(1);
    rx_packet_end = 1'b0;
    check("end strength", rssi_valid, 1'b1);
    check("unlocked", rx_locked, 1'b0);
  endtask

  task automatic test_tx;
    logic [31:0] seq;
    int t;
    tx_symbol_valid = 1'b1;
    tick(3);
    check("ready in receive", tx_symbol_ready, 1'b0);
    tx_mode = 1'b1;
    for (int s = 0; s < 6; s++) begin
      tx_symbol = TX_SYMS[s];
      seq = ref_seq(TX_SYMS[s]);
      wait_high(tx_symbol_ready, 5000, t);
      check("ready offered", tx_symbol_ready, 1'b1);
      tick(1);
      tx_symbol_valid = (s < 5);
      for (int k = 31; k >= 0; k--) begin
        wait_high(tx_chip_valid, 200, t);
        check("chip spacing", t, CHIP);
        check("chip value", tx_chip, seq[k]);
        check("busy", tx_symbol_ready, 1'b0);
      end
    end
    tick(2);
    tx_mode = 1'b0;
  endtask

  task automatic test_pins;
    for (int m = 0; m < 64; m++) begin
      {tx_mode, port_c5_alt_en, port_c5_gpio, port_c6_alt_en, port_c6_gpio, cal_write} = 6'(m);
      cal_in = 18'(m) * 18'h01003;
      tick(1);
      cal_write = 1'b0;
      tick(1);
    end
    tx_mode = 1'b0;
  endtask

  // ==========
  // clock and main sequence
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    {rst, rx_packet_end, tx_mode, tx_symbol_valid, cal_write, mon_on} = 6'h20;
    {port_c5_alt_en, port_c5_gpio, port_c6_alt_en, port_c6_gpio} = 4'h0;
    tx_symbol = 4'h0;
    cal_in = '0;
    cca_threshold = 8'h00;
    amp = 8'h05;
    n_fail = 0;
    check_count = 0;
    cycles = 0;
    tick(10);
    rst = 1'b0;
    tick(1);
    mon_on = 1'b1;
    check("gain at reset", rx_gain, baseband_pkg::GAIN_RESET);
    test_gain();
    test_rssi();
    test_rx();
    test_tx();
    test_pins();
    end_of_test();
  end
endmodule // radio_digital_baseband_test
`default_nettype wire
